// ===== bench/osrm_chk_monitor.sv
// assertions on the monitor top ports
// assumes a bind into osrm_monitor
module osrm_chk
	import osrm_pkg::*;
(
	input wire logic CLK,
	input wire logic NRST,
	input wire logic DETECT_ACTION_SELECT,
	input wire logic [1:0] CPU_SRC,
	input wire logic OSC_SELECT_WR,
	input wire logic WDT_IRQ,
	input wire logic OSC_SELECT,
	input wire logic DETECT_FLAG,
	input wire logic MAIN_STOPPED_STATUS,
	input wire logic PERIPH_CLK_OCO,
	input wire logic OCO_RUN,
	input wire logic SPECIAL_IRQ,
	input wire logic STOP_RESET_REQ
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	sequence s_stop;
		$rose(MAIN_STOPPED_STATUS);
	endsequence
	sequence s_go;
		$fell(MAIN_STOPPED_STATUS) && !$past(OSC_SELECT_WR);
	endsequence
	AST_STOP_IRQ: assert property (s_stop ##0 !$past(DETECT_FLAG) |-> SPECIAL_IRQ)
		else $error("stop without request");
	AST_MAIN_SW: assert property (s_stop ##0 $past(CPU_SRC) == OSRM_SRC_MAIN |->
		OSC_SELECT && DETECT_FLAG && PERIPH_CLK_OCO && OCO_RUN) else $error("no switch");
	AST_PLL_KEEP: assert property (s_stop ##0 $past(CPU_SRC) == OSRM_SRC_PLL && !$past(OSC_SELECT_WR) |->
		$stable(OSC_SELECT) && DETECT_FLAG) else $error("pll stop bits");
	AST_SUB_OCO: assert property (s_stop ##0 $past(CPU_SRC) == OSRM_SRC_SUB && !$past(OSC_SELECT_WR) |->
		PERIPH_CLK_OCO && OCO_RUN && $stable(OSC_SELECT)) else $error("sub stop bits");
	AST_RESTART: assert property (s_go |-> DETECT_FLAG && $stable(OSC_SELECT))
		else $error("restart bits");
	AST_BLOCK: assert property ($past(DETECT_FLAG) && !$past(WDT_IRQ) |-> !SPECIAL_IRQ)
		else $error("request while flag set");
	AST_WDT: assert property ($past(WDT_IRQ) |-> SPECIAL_IRQ)
		else $error("watchdog request lost");
	AST_RST_MODE: assert property ($rose(STOP_RESET_REQ) |->
		!$past(DETECT_ACTION_SELECT) && $stable(MAIN_STOPPED_STATUS)) else $error("reset mode");
endmodule

bind osrm_monitor osrm_chk u_chk (
	.CLK(CLK),
	.NRST(NRST),
	.DETECT_ACTION_SELECT(DETECT_ACTION_SELECT),
	.CPU_SRC(CPU_SRC),
	.OSC_SELECT_WR(OSC_SELECT_WR),
	.WDT_IRQ(WDT_IRQ),
	.OSC_SELECT(OSC_SELECT),
	.DETECT_FLAG(DETECT_FLAG),
	.MAIN_STOPPED_STATUS(MAIN_STOPPED_STATUS),
	.PERIPH_CLK_OCO(PERIPH_CLK_OCO),
	.OCO_RUN(OCO_RUN),
	.SPECIAL_IRQ(SPECIAL_IRQ),
	.STOP_RESET_REQ(STOP_RESET_REQ)
);

// ===== bench/osrm_osc.sv
// main oscillator model that halts and restarts on request
// assumes the bench keeps the half period well inside the stop window
module osrm_osc (
	input wire logic run,
	input var int half,
	output logic clk
);
	timeunit 1ns;
	timeprecision 1ps;
	initial clk = 1'b0;
	// a halted crystal holds its last level
	always begin
		if (run) #(half) clk = ~clk;
		else @(run);
	end
endmodule

// ===== bench/testbench.sv
// self-checking bench for the oscillation stop and restart monitor
// assumes test counts of 16 cycles for a stop and 2 edges for a restart
module testbench import osrm_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, nrst = 0, run = 1, de = 0, das = 1, wr = 0, wd = 0, clr = 0, wdt = 0;
	logic [1:0] src = 2'h0;
	logic mclk, osel, flag, mss, poco, orun, irq, rreq;
	int half = 10, seed = 32'ha8cb, n = 0, nirq = 0, miscompares = 0, comparisons = 0;
	bit eo, ef, em, ep, er, rr;
	// system and peripheral clock never stops, also across wait
	always #2 clk = ~clk;
	always @(posedge clk) if (irq === 1'b1) nirq++;
	osrm_osc u_osc (.run(run), .half(half), .clk(mclk));
	osrm_monitor #(.STOP_CYCLES(16), .RESTART_EDGES(2)) DUT (.CLK(clk), .NRST(nrst),
		.MAIN_CLK_IN(mclk), .DETECT_ENABLE(de), .DETECT_ACTION_SELECT(das), .CPU_SRC(src),
		.OSC_SELECT_WR(wr), .OSC_SELECT_WDATA(wd), .DETECT_FLAG_CLR(clr), .WDT_IRQ(wdt),
		.OSC_SELECT(osel), .DETECT_FLAG(flag), .MAIN_STOPPED_STATUS(mss),
		.PERIPH_CLK_OCO(poco), .OCO_RUN(orun), .SPECIAL_IRQ(irq), .STOP_RESET_REQ(rreq));
	task cmp(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task cmp_irq(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t request count %h expected %h", $time, got, exp);
		end
	endtask
	task conclude;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task sw(input w, input c, input d);
		@(posedge clk);
		wr <= w;
		clr <= c;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
		clr <= 1'b0;
		if (c) ef = 0;
		if (w) begin
			eo = d;
			ep = d;
			er |= d;
		end
	endtask
	// low r halts the main clock, high r restarts it at a random rate
	task ev(input r, input [1:0] s);
		@(posedge clk);
		src <= s;
		run <= r;
		half <= 8 + ($random(seed) & 7);
		if (de && !r && !das) rr = 1;
		else if (de && (!r || em)) begin
			if (!ef) n++;
			ef = 1;
			em = !r;
			if (!r && s != OSRM_SRC_PLL) begin
				ep = 1;
				er = 1;
			end
			if (!r && s == OSRM_SRC_MAIN) eo = 1;
		end
		repeat (40) @(posedge clk);
		cmp({2'h0, osel, flag, mss, poco, orun, rreq}, {2'h0, eo, ef, em, ep, er, rr});
		cmp_irq(nirq[7:0], n[7:0]);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		de <= 1'b1;
		ev(0, OSRM_SRC_MAIN);
		ev(1, OSRM_SRC_MAIN);
		sw(1, 1, 0);
		ev(0, OSRM_SRC_PLL);
		sw(1, 1, 1);
		ev(1, OSRM_SRC_PLL);
		sw(1, 1, 0);
		ev(0, OSRM_SRC_SUB);
		@(posedge clk);
		wdt <= 1'b1;
		@(posedge clk);
		wdt <= 1'b0;
		n++;
		ev(1, OSRM_SRC_SUB);
		sw(0, 1, 0);
		de <= 1'b0;
		ev(0, OSRM_SRC_MAIN);
		ev(1, OSRM_SRC_MAIN);
		de <= 1'b1;
		das <= 1'b0;
		ev(0, OSRM_SRC_MAIN);
		// reset request holds until a hardware reset, which clears every output
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		cmp({2'h0, osel, flag, mss, poco, orun, rreq}, 8'h00);
		conclude;
	end
	initial begin
		#20000;
		miscompares++;
		conclude;
	end
endmodule

// ===== src/osrm_monitor.sv
// main clock oscillation stop and restart monitor, top level
// assumes CLK runs from a source independent of the main clock; control bits are plain ports
//
// Overview of operation
// - interrupt behaviour applies only when the action select bit is one
// - action select zero with detection on: a stop requests a reset instead
// - main clock as cpu source stops: interrupt, start on-chip osc, switch cpu and peripherals
// - in that case set oscillator select, detect flag and stopped status
// - pll as cpu source stops: interrupt, flag and stopped set, select unchanged
// - restart after stop: interrupt, flag set, stopped cleared, select unchanged
// - interrupt shares the watchdog vector; software reads the flag to tell
// - flag set with the interrupt; while set further interrupts are blocked
// - stop in low speed mode: interrupt, on-chip osc starts, peripherals move, cpu stays
// - the interrupt is non-maskable, ignoring the enable flag and priority levels
`include "osrm_regs.svh"

module osrm_monitor
	import osrm_pkg::*;
#(
	parameter int STOP_CYCLES = `OSRM_STOP_CYCLES,
	parameter int RESTART_EDGES = `OSRM_RESTART_EDGES
) (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic MAIN_CLK_IN,
	input wire logic DETECT_ENABLE,
	input wire logic DETECT_ACTION_SELECT,
	input wire logic [1:0] CPU_SRC,
	input wire logic OSC_SELECT_WR,
	input wire logic OSC_SELECT_WDATA,
	input wire logic DETECT_FLAG_CLR,
	input wire logic WDT_IRQ,
	output logic OSC_SELECT,
	output logic DETECT_FLAG,
	output logic MAIN_STOPPED_STATUS,
	output logic PERIPH_CLK_OCO,
	output logic OCO_RUN,
	output logic SPECIAL_IRQ,
	output logic STOP_RESET_REQ
);

	localparam int GAP_W = $clog2(STOP_CYCLES + 1);
	localparam int EDGE_W = $clog2(RESTART_EDGES + 1);
	localparam logic [GAP_W-1:0] GAP_LIMIT = GAP_W'(STOP_CYCLES);
	localparam logic [EDGE_W-1:0] EDGE_LIMIT = EDGE_W'(RESTART_EDGES);

	logic main_rise;
	osrm_src_type cpu_src;

	osrm_state_type state_reg;
	osrm_state_type state_next;
	logic [GAP_W-1:0] gap_reg;
	logic [GAP_W-1:0] gap_next;
	logic [EDGE_W-1:0] edges_reg;
	logic [EDGE_W-1:0] edges_next;

	logic osc_select_reg;
	logic osc_select_next;
	logic flag_reg;
	logic flag_next;
	logic stopped_reg;
	logic stopped_next;
	logic periph_oco_reg;
	logic periph_oco_next;
	logic oco_run_reg;
	logic oco_run_next;
	logic irq_reg;
	logic irq_next;
	logic reset_req_reg;
	logic reset_req_next;

	logic stop_event;
	logic restart_event;
	logic irq_event;

	assign cpu_src = osrm_src_type'(CPU_SRC);

	osrm_sync #(
		.STAGES(`OSRM_SYNC_STAGES)
	) u_main_sync (
		.clk(CLK),
		.nrst(NRST),
		.din(MAIN_CLK_IN),
		.rise(main_rise)
	);

	// edge watch: gap counter and restart edge counter
	always_comb begin
		state_next = state_reg;
		gap_next = gap_reg;
		edges_next = edges_reg;
		stop_event = 1'b0;
		restart_event = 1'b0;
		if (main_rise || !DETECT_ENABLE) begin
			gap_next = '0;
		end else if (gap_reg != GAP_LIMIT) begin
			gap_next = gap_reg + GAP_W'(1);
		end
		case (state_reg)
			OSRM_ST_RUN: begin
				edges_next = '0;
				if (DETECT_ENABLE && !main_rise && gap_reg == GAP_LIMIT - GAP_W'(1)) begin
					stop_event = 1'b1;
					if (DETECT_ACTION_SELECT) begin
						state_next = OSRM_ST_STOPPED;
					end else begin
						state_next = OSRM_ST_RESET;
					end
				end
			end
			OSRM_ST_STOPPED: begin
				if (!DETECT_ENABLE) begin
					edges_next = '0;
				end else if (gap_reg == GAP_LIMIT) begin
					edges_next = main_rise ? EDGE_W'(1) : '0;
				end else if (main_rise) begin
					if (edges_reg == EDGE_LIMIT - EDGE_W'(1)) begin
						restart_event = 1'b1;
						edges_next = '0;
						state_next = OSRM_ST_RUN;
					end else begin
						edges_next = edges_reg + EDGE_W'(1);
					end
				end
			end
			OSRM_ST_RESET: begin
				edges_next = '0;
			end
			default: begin
				state_next = OSRM_ST_RUN;
				edges_next = '0;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			state_reg <= OSRM_ST_RUN;
			gap_reg <= '0;
			edges_reg <= '0;
		end else begin
			state_reg <= state_next;
			gap_reg <= gap_next;
			edges_reg <= edges_next;
		end
	end

	// status bits, clock steering and interrupt request
	always_comb begin
		osc_select_next = osc_select_reg;
		flag_next = flag_reg;
		stopped_next = stopped_reg;
		periph_oco_next = periph_oco_reg;
		oco_run_next = oco_run_reg;
		reset_req_next = reset_req_reg;
		irq_event = 1'b0;
		if (OSC_SELECT_WR) begin
			osc_select_next = OSC_SELECT_WDATA;
			periph_oco_next = OSC_SELECT_WDATA;
			if (OSC_SELECT_WDATA) begin
				oco_run_next = 1'b1;
			end
		end
		if (DETECT_FLAG_CLR) begin
			flag_next = 1'b0;
		end
		if (stop_event && !DETECT_ACTION_SELECT) begin
			reset_req_next = 1'b1;
		end else if (stop_event) begin
			stopped_next = 1'b1;
			irq_event = !flag_reg;
			flag_next = 1'b1;
			case (cpu_src)
				OSRM_SRC_MAIN: begin
					oco_run_next = 1'b1;
					osc_select_next = 1'b1;
					periph_oco_next = 1'b1;
				end
				OSRM_SRC_SUB: begin
					oco_run_next = 1'b1;
					periph_oco_next = 1'b1;
				end
				default: begin
					// pll or on-chip osc: clock steering left to software
				end
			endcase
		end else if (restart_event) begin
			stopped_next = 1'b0;
			irq_event = !flag_reg;
			flag_next = 1'b1;
		end
		// stop reason remains; request shares the watchdog line, no mask applies
		irq_next = irq_event | WDT_IRQ;
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			osc_select_reg <= `OSRM_OSC_SELECT_RST;
			flag_reg <= `OSRM_DETECT_FLAG_RST;
			stopped_reg <= `OSRM_MAIN_STOPPED_RST;
			periph_oco_reg <= 1'b0;
			oco_run_reg <= 1'b0;
			irq_reg <= 1'b0;
			reset_req_reg <= 1'b0;
		end else begin
			osc_select_reg <= osc_select_next;
			flag_reg <= flag_next;
			stopped_reg <= stopped_next;
			periph_oco_reg <= periph_oco_next;
			oco_run_reg <= oco_run_next;
			irq_reg <= irq_next;
			reset_req_reg <= reset_req_next;
		end
	end

	assign OSC_SELECT = osc_select_reg;
	assign DETECT_FLAG = flag_reg;
	assign MAIN_STOPPED_STATUS = stopped_reg;
	assign PERIPH_CLK_OCO = periph_oco_reg;
	assign OCO_RUN = oco_run_reg;
	assign SPECIAL_IRQ = irq_reg;
	assign STOP_RESET_REQ = reset_req_reg;

endmodule

// ===== src/osrm_pkg.sv
// types shared by the oscillation stop and restart monitor
// assumes nothing beyond a SystemVerilog compiler
package osrm_pkg;

	typedef enum logic [1:0] {
		OSRM_SRC_MAIN,
		OSRM_SRC_PLL,
		OSRM_SRC_SUB,
		OSRM_SRC_OCO
	} osrm_src_type;

	typedef enum logic [1:0] {
		OSRM_ST_RUN,
		OSRM_ST_STOPPED,
		OSRM_ST_RESET
	} osrm_state_type;

endpackage

// ===== src/osrm_regs.svh
// constants for the oscillation stop and restart monitor
// assumes a single 250 MHz system clock that keeps running while the main clock is gone
`ifndef OSRM_REGS_SVH
`define OSRM_REGS_SVH

`define OSRM_CLK_PERIOD_NS 4
// longest gap between main clock edges before a stop is recognised
`define OSRM_STOP_WINDOW_NS 1000
`define OSRM_STOP_CYCLES ((`OSRM_STOP_WINDOW_NS + `OSRM_CLK_PERIOD_NS - 1) / `OSRM_CLK_PERIOD_NS)
// edges in a row, each within the window, that count as a restart
`define OSRM_RESTART_EDGES 4
`define OSRM_SYNC_STAGES 2

`define OSRM_OSC_SELECT_RST 1'b0
`define OSRM_DETECT_FLAG_RST 1'b0
`define OSRM_MAIN_STOPPED_RST 1'b0

`endif

// ===== src/osrm_sync.sv
// two-stage synchroniser with rising edge detection behind it
// assumes the input is asynchronous to clk
`include "osrm_regs.svh"

module osrm_sync #(
	parameter int STAGES = `OSRM_SYNC_STAGES
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic din,
	output logic rise
);

	logic [STAGES-1:0] chain_reg;
	logic [STAGES-1:0] chain_next;
	logic last_reg;
	logic last_next;
	logic rise_reg;
	logic rise_next;

	always_comb begin
		chain_next = {chain_reg[STAGES-2:0], din};
		last_next = chain_reg[STAGES-1];
		rise_next = chain_reg[STAGES-1] & ~last_reg;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			chain_reg <= '0;
			last_reg <= 1'b0;
			rise_reg <= 1'b0;
		end else begin
			chain_reg <= chain_next;
			last_reg <= last_next;
			rise_reg <= rise_next;
		end
	end

	assign rise = rise_reg;

endmodule
